// ==== shared/thr_map.svh ====
// Purpose: Register offsets, field positions, reset values, timing counts
// Assumes: 40 MHz command clock, APB byte addressing
// Notes: Definitions only
`ifndef THR_MAP_SVH
`define THR_MAP_SVH

`define THR_OFF_CTRL_LOW 8'h00
`define THR_OFF_CTRL_HIGH 8'h04
`define THR_OFF_THRESH 8'h08
`define THR_OFF_STATUS 8'h0c

// thermal_ctrl_low fields
`define THR_GSW_LSB 0
`define THR_GSW_MSB 7
`define THR_TTM_LSB 8
`define THR_TTM_MSB 13
`define THR_WSEL_LSB 28
`define THR_WSEL_MSB 29
`define THR_EN_BIT 31
// thermal_ctrl_high fields
`define THR_TAM_LSB 0
`define THR_TAM_MSB 15
`define THR_TMW_LSB 16
`define THR_TMW_MSB 31

`define THR_RST_CTRL_LOW 32'h0000_0000
`define THR_RST_CTRL_HIGH 32'h0000_0000
`define THR_RST_THRESH 32'hffff_ffff

// Command weight fixed; activate weight is base plus select field
`define THR_CMD_WEIGHT 3'h2
`define THR_ACT_WEIGHT_BASE 3'h2

// Sampling window step, in its own unit, and the clock rate
`define THR_STEP_NS 4000000
`define THR_CLK_MHZ 40
`define THR_STEP_CYCLES (`THR_STEP_NS * `THR_CLK_MHZ / 1000)

`endif

// ==== shared/thr_pkg.sv ====
// Purpose: Types shared by the thermal throttle design
// Assumes: Nothing beyond the map header
// Notes: Configuration travels as one packed struct
package thr_pkg;

  typedef struct packed {
    logic en;
    logic [7:0] gsw;
    logic [5:0] ttm;
    logic [1:0] wsel;
    logic [15:0] throttle_activity_max;
    logic [15:0] throttle_monitor_window;
    logic [31:0] global_activity_threshold;
  } cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_THROTTLE = 2'b10
  } state_t;

endpackage

// ==== hw/activity_accum.sv ====
// Purpose: Saturating weighted activity counter for one memory module
// Assumes: Activate and command strobes are same-clock pulses
// Notes: Clear reloads with this cycle's weight so no event is lost
`timescale 1ns/1ps
`default_nettype none
module activity_accum #(
  parameter int CW = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic act,
  input wire logic cmd,
  input wire logic [2:0] act_w,
  input wire logic [2:0] cmd_w,
  output logic [CW-1:0] count
);
  logic [CW-1:0] count_q;
  logic [CW:0] sum_d;
  logic [CW-1:0] inc;

  always_comb begin
    inc = '0;
    if (act) begin
      inc = inc + CW'(act_w);
    end
    if (cmd) begin
      inc = inc + CW'(cmd_w);
    end
    sum_d = {1'b0, (clr ? {CW{1'b0}} : count_q)} + {1'b0, inc};
  end

  // Saturate: a wrapped count would hide a hot module
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (sum_d[CW]) begin
      count_q <= '1;
    end else begin
      count_q <= sum_d[CW-1:0];
    end
  end

  assign count = count_q;
endmodule
`default_nettype wire

// ==== hw/window_timer.sv ====
// Purpose: Global sampling window timer in 4 ms steps
// Assumes: Step length given in command clock cycles
// Notes: Length zero gives no window end at all
`timescale 1ns/1ps
`default_nettype none
module window_timer #(
  parameter int STEP_CYCLES = 160000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [7:0] steps,
  output logic win_end
);
  logic [31:0] div_q;
  logic [7:0] step_q;
  logic tick;
  logic win_end_q;

  assign tick = run && (div_q == 32'(STEP_CYCLES - 1));

  // Step divider, one-cycle tick per step
  always_ff @(posedge clk) begin
    if (rst || !run || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      step_q <= '0;
      win_end_q <= 1'b0;
    end else if (tick && steps != 8'h00) begin
      win_end_q <= (step_q == steps - 8'h01);
      step_q <= (step_q == steps - 8'h01) ? 8'h00 : step_q + 8'h01;
    end else begin
      win_end_q <= 1'b0;
    end
  end

  assign win_end = win_end_q;
endmodule
`default_nettype wire

// ==== hw/dram_thermal_throttle.sv ====
// Purpose: Thermal throttling of DRAM traffic per memory module activity
// Assumes: Scheduler on MCLK, one activate/command strobe per module
// Notes: Registers over APB with one wait state per access
`timescale 1ns/1ps
`default_nettype none
`include "thr_map.svh"

// Notes on behaviour
// - Weighted activate and command count per module
// - Activate weight select at low control 29:28
// - Activate plus read costs five at 3:2
// - Threshold compared with one window's weighted count
// - Sampling window counted in command clock cycles
// - Window in 4 ms steps; zero disables
// - No restriction while only sampling
// - Throttle lasts multiple times window length
// - Cap each module per monitor window
// - Any module over cap stops all traffic
// - Any module over threshold engages throttling
// - Rearm detection when throttle time expires
module dram_thermal_throttle
  import thr_pkg::*;
#(
  parameter int NMOD = 4,
  parameter int CW = 32,
  parameter int STEP_CYCLES = `THR_STEP_CYCLES
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [NMOD-1:0] ACT_ISSUED,
  input wire logic [NMOD-1:0] CMD_ISSUED,
  output logic TRAFFIC_STOP,
  output logic THROTTLE_ACTIVE
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [31:0] ctrl_low_q;
  logic [31:0] ctrl_high_q;
  logic [31:0] thresh_q;
  cfg_t cfg;
  state_t state_q;
  logic [5:0] remain_q;
  logic [15:0] trips_q;
  logic [15:0] mw_q;
  logic stop_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  always_comb begin
    cfg.en = ctrl_low_q[`THR_EN_BIT];
    cfg.gsw = ctrl_low_q[`THR_GSW_MSB:`THR_GSW_LSB];
    cfg.ttm = ctrl_low_q[`THR_TTM_MSB:`THR_TTM_LSB];
    cfg.wsel = ctrl_low_q[`THR_WSEL_MSB:`THR_WSEL_LSB];
    cfg.throttle_activity_max = ctrl_high_q[`THR_TAM_MSB:`THR_TAM_LSB];
    cfg.throttle_monitor_window = ctrl_high_q[`THR_TMW_MSB:`THR_TMW_LSB];
    cfg.global_activity_threshold = thresh_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  logic acc;
  logic wr_go;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] bmask;

  assign acc = PSEL && PENABLE;
  // Write lands only on the edge where the master sees pready high
  assign wr_go = acc && pready_q && PWRITE && !pslverr_q;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (PADDR)
      `THR_OFF_CTRL_LOW: rd_mux = ctrl_low_q;
      `THR_OFF_CTRL_HIGH: rd_mux = ctrl_high_q;
      `THR_OFF_THRESH: rd_mux = thresh_q;
      `THR_OFF_STATUS: rd_mux = {trips_q, 2'b00, remain_q,
                                 5'b00000, stop_q, state_q};
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bmask[i*8 +: 8] = {8{PSTRB[i]}};
    end
  end

  // One wait state, so the answer comes from flip-flops
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (acc && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped || (PWRITE && PADDR == `THR_OFF_STATUS);
      prdata_q <= (PWRITE || !mapped) ? 32'h0000_0000 : rd_mux;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Fields may change live; firmware sets them before enabling
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ctrl_low_q <= `THR_RST_CTRL_LOW;
      ctrl_high_q <= `THR_RST_CTRL_HIGH;
      thresh_q <= `THR_RST_THRESH;
    end else if (wr_go) begin
      case (PADDR)
        `THR_OFF_CTRL_LOW: begin
          ctrl_low_q <= (ctrl_low_q & ~bmask) | (PWDATA & bmask);
        end
        `THR_OFF_CTRL_HIGH: begin
          ctrl_high_q <= (ctrl_high_q & ~bmask) | (PWDATA & bmask);
        end
        `THR_OFF_THRESH: begin
          thresh_q <= (thresh_q & ~bmask) | (PWDATA & bmask);
        end
        default: begin
          ctrl_low_q <= ctrl_low_q;
        end
      endcase
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Weights and sampling window

  logic [2:0] act_w;
  logic [2:0] cmd_w;
  logic run;
  logic win_end;

  // Select 01 gives 3:2, so activate plus read costs five
  assign act_w = `THR_ACT_WEIGHT_BASE + {1'b0, cfg.wsel};
  assign cmd_w = `THR_CMD_WEIGHT;
  assign run = cfg.en && cfg.gsw != 8'h00;

  window_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .clk(MCLK),
    .rst(SYS_RST),
    .run(run),
    .steps(cfg.gsw),
    .win_end(win_end)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-module counters

  logic [NMOD-1:0] over_gat;
  logic [NMOD-1:0] over_tam;
  logic mw_end;
  logic throttling;
  logic samp_clr;
  logic mon_clr;

  assign throttling = state_q == ST_THROTTLE;
  assign samp_clr = win_end || !run;
  assign mon_clr = mw_end || !throttling;

  genvar g;
  generate
    for (g = 0; g < NMOD; g++) begin : g_mod
      logic [CW-1:0] samp_cnt;
      logic [CW-1:0] mon_cnt;

      activity_accum #(
        .CW(CW)
      ) u_samp (
        .clk(MCLK),
        .rst(SYS_RST),
        .clr(samp_clr),
        .act(ACT_ISSUED[g]),
        .cmd(CMD_ISSUED[g]),
        .act_w(act_w),
        .cmd_w(cmd_w),
        .count(samp_cnt)
      );

      activity_accum #(
        .CW(CW)
      ) u_mon (
        .clk(MCLK),
        .rst(SYS_RST),
        .clr(mon_clr),
        .act(ACT_ISSUED[g]),
        .cmd(CMD_ISSUED[g]),
        .act_w(act_w),
        .cmd_w(cmd_w),
        .count(mon_cnt)
      );

      assign over_gat[g] = CW'(cfg.global_activity_threshold) < samp_cnt;
      assign over_tam[g] = CW'(cfg.throttle_activity_max) < mon_cnt;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Throttle state

  logic trip;

  // Count is judged on the window-end edge, before it is cleared
  assign trip = win_end && (|over_gat) && cfg.ttm != 6'h00;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_q <= ST_IDLE;
      remain_q <= 6'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (run) begin
            state_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (!run) begin
            state_q <= ST_IDLE;
          end else if (trip) begin
            state_q <= ST_THROTTLE;
            remain_q <= cfg.ttm;
          end
        end
        ST_THROTTLE: begin
          if (!run) begin
            state_q <= ST_IDLE;
            remain_q <= 6'h00;
          end else if (win_end) begin
            remain_q <= remain_q - 6'h01;
            if (remain_q == 6'h01) begin
              state_q <= ST_SAMPLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          remain_q <= 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      trips_q <= 16'h0000;
    end else if (trip && state_q == ST_SAMPLE && trips_q != 16'hffff) begin
      trips_q <= trips_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor window and traffic stop

  logic [15:0] mw_last;

  // Length zero is taken as one cycle so the window always ends
  assign mw_last = (cfg.throttle_monitor_window == 16'h0000) ? 16'h0000 : cfg.throttle_monitor_window - 16'h0001;
  assign mw_end = throttling && mw_q == mw_last;

  always_ff @(posedge MCLK) begin
    if (SYS_RST || !throttling || mw_end) begin
      mw_q <= 16'h0000;
    end else begin
      mw_q <= mw_q + 16'h0001;
    end
  end

  // Stop lags the offending count by one edge; scheduler sees it late
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !throttling) begin
      stop_q <= 1'b0;
    end else if (mw_end) begin
      stop_q <= 1'b0;
    end else if (|over_tam) begin
      stop_q <= 1'b1;
    end
  end

  logic active_q;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      active_q <= 1'b0;
    end else begin
      active_q <= throttling;
    end
  end

  assign TRAFFIC_STOP = stop_q;
  assign THROTTLE_ACTIVE = active_q;

endmodule
`default_nettype wire

// ==== test/thr_props.sv ====
// Purpose: Port checks for the throttle block
// Assumes: Bench uses one 8-cycle window step
// Notes: Bound onto the top module below
`timescale 1ns/1ps
`default_nettype none
module thr_props (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TRAFFIC_STOP,
  input wire logic THROTTLE_ACTIVE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  logic [15:0] tmw_q;
  logic [15:0] run_q;
  ////////////////////////////////////////////////////////////////////////
  // Shadow of the monitor window length, byte lanes honoured
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      tmw_q <= 16'h0;
    end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h04) begin
      if (PSTRB[2]) begin
        tmw_q[7:0] <= PWDATA[23:16];
      end
      if (PSTRB[3]) begin
        tmw_q[15:8] <= PWDATA[31:24];
      end
    end
  end
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !TRAFFIC_STOP)
      run_q <= 16'h0;
    else
      run_q <= run_q + 16'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  a_rdy_latency: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  a_rdy_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  a_rdy_cause: assert property (!(PSEL && PENABLE) |=> !PREADY)
    else $error("ready unasked");
  a_err_unmapped: assert property (PREADY && PADDR > 8'h0c
    |-> PSLVERR && PRDATA == 32'h0) else $error("unmapped ok");
  a_err_status: assert property (PREADY && PWRITE && PADDR == 8'h0c
    |-> PSLVERR) else $error("status write ok");
  a_err_only: assert property (PSLVERR |-> PREADY
    && (PADDR > 8'h0c || PADDR[1:0] != 2'b00
    || PWRITE && PADDR == 8'h0c)) else $error("bad err");
  a_stop_throttle: assert property (
    $rose(TRAFFIC_STOP) |-> THROTTLE_ACTIVE) else $error("stop unthrottled");
  a_stop_bounded: assert property (run_q <= tmw_q)
    else $error("stop outlived window");
  a_throttle_holds: assert property (
    $rose(THROTTLE_ACTIVE) |-> THROTTLE_ACTIVE[*8]) else $error("short");
endmodule
bind dram_thermal_throttle thr_props props (.*);
`default_nettype wire

// ==== test/sched_model.sv ====
// Purpose: Command scheduler stand-in
// Assumes: Requests come from the bench
// Notes: Combinational gate, so a stop blocks the same cycle
`timescale 1ns/1ps
`default_nettype none
module sched_model #(
  parameter int NMOD = 4
) (
  input wire logic [NMOD-1:0] act_req,
  input wire logic [NMOD-1:0] cmd_req,
  input wire logic stop,
  output logic [NMOD-1:0] act,
  output logic [NMOD-1:0] cmd
);
  assign act = stop ? {NMOD{1'b0}} : act_req;
  assign cmd = stop ? {NMOD{1'b0}} : cmd_req;
endmodule
`default_nettype wire

// ==== test/dram_thermal_throttle_test.sv ====
// Purpose: Self-checking bench for the throttle block
// Assumes: Window step shortened to 8 cycles
// Notes: Scheduler model gates traffic on stop
`timescale 1ns/1ps
`default_nettype none
module dram_thermal_throttle_test;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] act_req = 4'h0;
  logic [3:0] cmd_req = 4'h0;
  logic [3:0] act;
  logic [3:0] cmd;
  logic stop;
  logic throt;
  logic [31:0] q;
  logic e;
  int err_count = 0;
  int total_checks = 0;
  always #12.5 mclk = ~mclk;
  dram_thermal_throttle #(.STEP_CYCLES(8)) uut (.MCLK(mclk),
    .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .ACT_ISSUED(act),
    .CMD_ISSUED(cmd), .TRAFFIC_STOP(stop), .THROTTLE_ACTIVE(throt));
  sched_model partner (.act_req(act_req), .cmd_req(cmd_req),
    .stop(stop), .act(act), .cmd(cmd));
  ////////////////////////////////////////////////////////////////////////
  function automatic bit bump(input bit bad);
    total_checks++;
    return bad;
  endfunction
  task automatic fail(input string m);
    err_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Request held until ready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      fail("no ready");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int m);
    @(posedge mclk);
    act_req[m] <= 1'b1;
    cmd_req[m] <= 1'b1;
    @(posedge mclk);
    act_req[m] <= 1'b0;
    cmd_req[m] <= 1'b0;
  endtask
  task automatic see(input int n, output bit s);
    s = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      if (throt === 1'b1)
        s = 1'b1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_regs;
    apb(1'b0, 8'h00, 32'h0);
    if (bump(q !== 32'h0)) fail("low ctrl reset");
    apb(1'b0, 8'h08, 32'h0);
    if (bump(q !== 32'hffff_ffff)) fail("threshold reset");
    apb(1'b0, 8'h10, 32'h0);
    if (bump(e !== 1'b1 || q !== 32'h0)) fail("unmapped read");
    apb(1'b1, 8'h0c, 32'h3);
    if (bump(e !== 1'b1)) fail("status write");
    apb(1'b0, 8'h0c, 32'h0);
    if (bump(q[1:0] !== 2'h0)) fail("status not idle");
    pstrb <= 4'h2;
    apb(1'b1, 8'h04, 32'hffff_ffff);
    pstrb <= 4'hf;
    apb(1'b0, 8'h04, 32'h0);
    if (bump(q !== 32'h0000_ff00)) fail("byte lanes");
    apb(1'b1, 8'h04, 32'h0);
    $display("test_regs done");
  endtask
  task automatic test_window;
    bit s;
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'h8000_0100);
    pulse(1);
    see(40, s);
    if (bump(s !== 1'b0)) fail("zero window ran");
    apb(1'b1, 8'h00, 32'h8000_0102);
    pulse(1);
    see(8, s);
    if (bump(s !== 1'b0)) fail("window too short");
    see(16, s);
    if (bump(s !== 1'b1)) fail("window no trip");
    apb(1'b1, 8'h00, 32'h0);
    $display("test_window done");
  endtask
  // Activate weighs 2+sel, command 2; equal to threshold is no trip
  task automatic test_weight;
    bit s;
    for (int w = 0; w < 4; w++) begin
      for (int k = 0; k < 2; k++) begin
        apb(1'b1, 8'h08, 32'(3 + w + k));
        apb(1'b1, 8'h00, {2'h2, 2'(w), 28'h000_0101});
        pulse(2);
        if (k == 1)
          repeat (8) @(posedge mclk);
        if (k == 1)
          pulse(2);
        see(24, s);
        if (bump(s !== (k == 0))) fail("weighted trip");
        apb(1'b1, 8'h00, 32'h0);
      end
    end
    $display("test_weight done");
  endtask
  task automatic test_cap;
    bit s;
    int n;
    apb(1'b1, 8'h04, 32'h0006_0003);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'h8000_0201);
    pulse(0);
    see(12, s);
    if (bump(s !== 1'b1)) fail("no throttle");
    act_req <= 4'h1;
    cmd_req <= 4'h2;
    n = 0;
    while (stop !== 1'b1 && n < 8) begin
      @(posedge mclk);
      n++;
    end
    if (bump(stop !== 1'b1)) fail("cap not kept");
    while (stop === 1'b1 && n < 16) begin
      @(posedge mclk);
      n++;
    end
    if (bump(stop !== 1'b0)) fail("stop not lifted");
    act_req <= 4'h0;
    cmd_req <= 4'h0;
    while (throt === 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    if (bump(throt !== 1'b0 || n < 13)) fail("throttle span");
    apb(1'b0, 8'h0c, 32'h0);
    if (bump(q[1:0] !== 2'h1)) fail("not sampling");
    pulse(0);
    see(12, s);
    if (bump(s !== 1'b1)) fail("not rearmed");
    apb(1'b1, 8'h00, 32'h0);
    $display("test_cap done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    test_regs;
    test_window;
    test_weight;
    test_cap;
    print_verdict;
  end
  initial begin
    #400000;
    fail("timeout");
    print_verdict;
  end
endmodule
`default_nettype wire
